//--- src/uprc_top.v
// What this block does
// [R01] Selection byte changes only after high-byte keys 0x78 then 0x9A.
// [R02] Low byte changes only after low-byte keys 0x46 then 0x57.
// [R03] Setting bit 0 after the low unlock starts an oscillator switch.
// [R04] USB logic gets a continuous 48 MHz clock while USB is enabled; here it runs only with the multiplier, so not in Sleep without keep-on.
// [R05] Primary input prescaled to 4 MHz, feeding the 96 MHz multiplier.
// [R06] USB branch divides the multiplier output by two.
// [R07] System branch divides by three, then by the postscaler.
// [R08] Postscaler codes 00..11 give 32, 16, 8, 4 MHz.
// [R09] Prescaler code 000..101 divides 1..6, 110 by 8, 111 by 12.
// [R10] USB clock only in primary-with-multiplier modes; no separate input.
// [R11] Secondary oscillator starts on module demand or software force-on.
// [R12] Modes 11/01 make pins oscillator pins; 00 frees them for I/O.
// [R13] Mode 01 selects low drive; otherwise high drive.
// [R14] External clock mode: pin clock used, driver off, force-on ignored.
// [R15] Half-frequency clock out driven in enabled primary modes.
// [R16] Bit 15 drives the divided reference clock onto its pin.
// [R17] Bits 11-8 divide the base clock by two to the code.
// [R18] Bit 12 set picks primary oscillator, clear picks system clock.
// [R19] Bit 13 keeps the reference running in Sleep.
// [R20] Sleep output needs bits 13 and 12; primary needs keep-on bit.
// [R21] Reference control bit 14 and bits 7-0 read zero.
// [R22] Postscaler sits at bits 7-6 of the clock divider register.
// [R23] Reference divider held cleared while the output is disabled.
// Assumes an APB master on clk; oscillator pins arrive synchronous to clk.
`timescale 1ns/1ps
`include "uprc_regs.vh"
module uprc_top (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire posc_clk_in,
    input wire secondary_ext_clk_pin,
    input wire secondary_osc_clk_in,
    input wire secondary_osc_request,
    input wire usb_en,
    input wire sleep,
    output wire pre_tick,
    output wire usb_clk_ok,
    output reg [15:0] usb_cycle_cnt_q,
    output reg [15:0] sys_cycle_cnt_q,
    output wire secondary_osc_run,
    output wire secondary_osc_driver_en,
    output wire secondary_osc_low_drive,
    output wire secondary_pins_digital,
    output wire secondary_clk,
    output wire primary_osc_power,
    output reg half_freq_clk_out,
    output wire half_freq_clk_out_oe,
    output wire ref_clk_pin,
    output wire ref_clk_pin_oe
);
    // Register state
    reg [2:0] cur_src_q;
    reg [2:0] new_src_q;
    reg switch_q;
    reg sec_force_q;
    reg [1:0] postdiv_q;
    reg pll_en_q;
    reg ref_oe_q;
    reg ref_slp_q;
    reg ref_sel_q;
    reg [3:0] ref_div_q;
    reg [2:0] prediv_q;
    reg [1:0] sec_mode_q;
    reg posc_keep_q;
    reg half_en_q;

    // Clock path state
    reg posc_last_q;
    reg [3:0] pre_cnt_q;
    reg [3:0] pre_lim;
    wire posc_rise;
    wire pll_mode;
    wire pll_run;
    wire ref_run;
    wire [3:0] sys_inc;
    wire [3:0] base_inc;

    // APB decode
    wire wr_acc;
    wire mapped;
    wire hi_wr;
    wire lo_wr;
    wire hi_open;
    wire lo_open;
    wire [15:0] osc_rd;
    wire [15:0] div_rd;
    wire [15:0] ref_rd;
    wire [15:0] cfg_rd;

    assign pready = 1'b1;
    assign mapped = (paddr == `UPRC_OFS_OSC_CTRL) || (paddr == `UPRC_OFS_CLK_DIV) ||
                    (paddr == `UPRC_OFS_REF_CTRL) || (paddr == `UPRC_OFS_CONFIG) ||
                    (paddr == `UPRC_OFS_USB_CNT) || (paddr == `UPRC_OFS_SYS_CNT);
    assign pslverr = psel && penable && !mapped;
    assign wr_acc = psel && penable && pwrite && mapped;
    assign hi_wr = wr_acc && (paddr == `UPRC_OFS_OSC_CTRL) && pstrb[1];
    assign lo_wr = wr_acc && (paddr == `UPRC_OFS_OSC_CTRL) && pstrb[0];

    uprc_unlock #(
        .KEY1(`UPRC_KEY_HI1),
        .KEY2(`UPRC_KEY_HI2)
    ) u_hi_lock (
        .clk(clk),
        .nrst(nrst),
        .wr(hi_wr),
        .data(pwdata[15:8]),
        .open(hi_open)
    );

    uprc_unlock #(
        .KEY1(`UPRC_KEY_LO1),
        .KEY2(`UPRC_KEY_LO2)
    ) u_lo_lock (
        .clk(clk),
        .nrst(nrst),
        .wr(lo_wr),
        .data(pwdata[7:0]),
        .open(lo_open)
    );

    // Oscillator control: selection and low byte are guarded by the keys
    always @(posedge clk) begin
        if (!nrst) begin
            cur_src_q <= `UPRC_SRC_RESET;
            new_src_q <= `UPRC_SRC_RESET;
            switch_q <= 1'b0;
            sec_force_q <= 1'b0;
        end else begin
            if (hi_wr && hi_open) begin
                new_src_q <= pwdata[`UPRC_OSC_NEW_LO+2:`UPRC_OSC_NEW_LO]; // R01
            end
            if (lo_wr && lo_open) begin
                sec_force_q <= pwdata[`UPRC_OSC_SEC_ON]; // R02
                switch_q <= pwdata[`UPRC_OSC_SWITCH]; // R03
            end else if (switch_q) begin
                // Redundant switch just clears; otherwise take the new source
                cur_src_q <= new_src_q; // R03
                switch_q <= 1'b0;
            end
        end
    end

    // Plain registers: clock divider, reference control, configuration
    always @(posedge clk) begin
        if (!nrst) begin
            postdiv_q <= 2'h0;
            pll_en_q <= 1'b0;
            ref_oe_q <= 1'b0;
            ref_slp_q <= 1'b0;
            ref_sel_q <= 1'b0;
            ref_div_q <= 4'h0;
            prediv_q <= 3'h0;
            sec_mode_q <= `UPRC_SEC_MODE_RST;
            posc_keep_q <= 1'b0;
            half_en_q <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == `UPRC_OFS_CLK_DIV && pstrb[0]) begin
                postdiv_q <= pwdata[`UPRC_DIV_POST_LO+1:`UPRC_DIV_POST_LO]; // R22
                pll_en_q <= pwdata[`UPRC_DIV_PLLEN];
            end
            if (paddr == `UPRC_OFS_REF_CTRL && pstrb[1]) begin
                ref_oe_q <= pwdata[`UPRC_REF_OE];
                ref_slp_q <= pwdata[`UPRC_REF_SLP];
                ref_sel_q <= pwdata[`UPRC_REF_SEL];
                ref_div_q <= pwdata[`UPRC_REF_DIV_LO+3:`UPRC_REF_DIV_LO];
            end
            if (paddr == `UPRC_OFS_CONFIG && pstrb[0]) begin
                prediv_q <= pwdata[`UPRC_CFG_PREDIV_LO+2:`UPRC_CFG_PREDIV_LO];
                sec_mode_q <= pwdata[`UPRC_CFG_SEC_LO+1:`UPRC_CFG_SEC_LO];
                posc_keep_q <= pwdata[`UPRC_CFG_POSC_ON];
                half_en_q <= pwdata[`UPRC_CFG_HALF_EN];
            end
        end
    end

    // Read data
    assign osc_rd = {1'b0, cur_src_q, 1'b0, new_src_q, 2'h0, pll_run, 3'h0,
                     sec_force_q, switch_q};
    assign div_rd = {8'h00, postdiv_q, pll_en_q, 5'h00};
    assign ref_rd = {ref_oe_q, 1'b0, ref_slp_q, ref_sel_q, ref_div_q, 8'h00}; // R21
    assign cfg_rd = {8'h00, half_en_q, posc_keep_q, sec_mode_q, 1'b0, prediv_q};

    always @* begin
        case (paddr)
            `UPRC_OFS_OSC_CTRL: prdata = {16'h0000, osc_rd};
            `UPRC_OFS_CLK_DIV: prdata = {16'h0000, div_rd};
            `UPRC_OFS_REF_CTRL: prdata = {16'h0000, ref_rd};
            `UPRC_OFS_CONFIG: prdata = {16'h0000, cfg_rd};
            `UPRC_OFS_USB_CNT: prdata = {16'h0000, usb_cycle_cnt_q};
            `UPRC_OFS_SYS_CNT: prdata = {16'h0000, sys_cycle_cnt_q};
            default: prdata = 32'h00000000;
        endcase
    end

    // Prescaler: no frequency sensing, divisor comes from the config field
    always @* begin
        case (prediv_q)
            3'h6: pre_lim = `UPRC_PRE_LIM_DIV8; // R09
            3'h7: pre_lim = `UPRC_PRE_LIM_DIV12; // R09
            default: pre_lim = {1'b0, prediv_q}; // R09
        endcase
    end

    assign posc_rise = posc_clk_in && !posc_last_q;
    assign pll_mode = (cur_src_q == `UPRC_SRC_POSC_PLL);
    assign pll_run = pll_mode && pll_en_q && primary_osc_power;
    assign pre_tick = pll_run && posc_rise && (pre_cnt_q == pre_lim); // R05

    always @(posedge clk) begin
        if (!nrst) begin
            posc_last_q <= 1'b0;
            pre_cnt_q <= 4'h0;
        end else begin
            posc_last_q <= posc_clk_in;
            if (!pll_run) begin
                pre_cnt_q <= 4'h0;
            end else if (posc_rise) begin
                pre_cnt_q <= (pre_cnt_q == pre_lim) ? 4'h0 : pre_cnt_q + 4'h1; // R05
            end
        end
    end

    // Each 4 MHz tick is 24 multiplier cycles: 12 USB cycles and 8 system
    // cycles before the postscaler; counters let software see the branches run
    assign sys_inc = `UPRC_SYS_PER_TICK >> postdiv_q; // R07 R08
    assign usb_clk_ok = usb_en && pll_run; // R04 R10

    always @(posedge clk) begin
        if (!nrst) begin
            usb_cycle_cnt_q <= 16'h0000;
            sys_cycle_cnt_q <= 16'h0000;
        end else if (pre_tick) begin
            usb_cycle_cnt_q <= usb_cycle_cnt_q + `UPRC_USB_PER_TICK; // R06
            sys_cycle_cnt_q <= sys_cycle_cnt_q + {12'h000, sys_inc}; // R07
        end
    end

    // Secondary oscillator
    assign secondary_pins_digital = (sec_mode_q == `UPRC_SEC_DIGITAL); // R12
    assign secondary_osc_low_drive = (sec_mode_q == `UPRC_SEC_LOWPWR); // R13
    assign secondary_osc_run = !secondary_pins_digital &&
        ((sec_mode_q == `UPRC_SEC_EXTCLK) || secondary_osc_request || sec_force_q); // R11
    assign secondary_osc_driver_en = secondary_osc_run &&
                                     (sec_mode_q != `UPRC_SEC_EXTCLK); // R14
    assign secondary_clk = (sec_mode_q == `UPRC_SEC_EXTCLK) ? secondary_ext_clk_pin :
                           (secondary_osc_driver_en && secondary_osc_clk_in); // R14

    // Primary oscillator drops in Sleep unless kept on
    assign primary_osc_power = !sleep || posc_keep_q; // R20

    // Half-frequency output in primary modes when enabled
    assign half_freq_clk_out_oe = half_en_q &&
        ((cur_src_q == `UPRC_SRC_POSC) || pll_mode); // R15

    always @(posedge clk) begin
        if (!nrst || !half_freq_clk_out_oe) begin
            half_freq_clk_out <= 1'b0;
        end else if (posc_rise && primary_osc_power) begin
            half_freq_clk_out <= ~half_freq_clk_out; // R15
        end
    end

    // Reference output; system base stops in Sleep by itself
    assign ref_run = ref_oe_q && (!sleep || ref_slp_q); // R19 R20
    assign base_inc = ref_sel_q ? {3'h0, posc_rise && primary_osc_power} : // R18
                      (sleep ? 4'h0 : (pre_tick ? sys_inc : 4'h0)); // R18
    assign ref_clk_pin_oe = ref_oe_q; // R16

    uprc_refdiv u_refdiv (
        .clk(clk),
        .nrst(nrst),
        .hold(!ref_run), // R23
        .inc(base_inc),
        .div(ref_div_q), // R17
        .pass(ref_sel_q),
        .pass_lvl(posc_clk_in && primary_osc_power),
        .q(ref_clk_pin) // R16
    );
endmodule // uprc_top

//--- src/uprc_regs.vh
// Register map, field positions, reset values and codes of the USB PLL and reference clock block.
// Included by the top module of the block only; definitions only.
`ifndef UPRC_REGS_VH
`define UPRC_REGS_VH

// Word offsets on the APB
`define UPRC_OFS_OSC_CTRL 8'h00
`define UPRC_OFS_CLK_DIV 8'h04
`define UPRC_OFS_REF_CTRL 8'h08
`define UPRC_OFS_CONFIG 8'h0C
`define UPRC_OFS_USB_CNT 8'h10
`define UPRC_OFS_SYS_CNT 8'h14

// Unlock keys
`define UPRC_KEY_HI1 8'h78
`define UPRC_KEY_HI2 8'h9A
`define UPRC_KEY_LO1 8'h46
`define UPRC_KEY_LO2 8'h57

// Oscillator control fields
`define UPRC_OSC_SWITCH 0
`define UPRC_OSC_SEC_ON 1
`define UPRC_OSC_LOCK 5
`define UPRC_OSC_NEW_LO 8
`define UPRC_OSC_CUR_LO 12

// Clock divider fields
`define UPRC_DIV_PLLEN 5
`define UPRC_DIV_POST_LO 6

// Reference control fields
`define UPRC_REF_OE 15
`define UPRC_REF_SLP 13
`define UPRC_REF_SEL 12
`define UPRC_REF_DIV_LO 8

// Config fields
`define UPRC_CFG_PREDIV_LO 0
`define UPRC_CFG_SEC_LO 4
`define UPRC_CFG_POSC_ON 6
`define UPRC_CFG_HALF_EN 7

// Source codes and secondary modes
`define UPRC_SRC_POSC 3'h2
`define UPRC_SRC_POSC_PLL 3'h3
`define UPRC_SRC_RESET 3'h0
`define UPRC_SEC_DIGITAL 2'h0
`define UPRC_SEC_LOWPWR 2'h1
`define UPRC_SEC_EXTCLK 2'h2
`define UPRC_SEC_MODE_RST 2'h3

// Prescaler terminal counts for the two non-linear codes
`define UPRC_PRE_LIM_DIV8 4'h7
`define UPRC_PRE_LIM_DIV12 4'hB

// Multiplier bookkeeping per 4 MHz tick: 96/4/2 and 96/4/3
`define UPRC_USB_PER_TICK 16'h000C
`define UPRC_SYS_PER_TICK 4'h8

`endif

//--- src/uprc_unlock.v
// Two-key byte unlock sequencer for one byte lane of the oscillator control register.
// Assumes wr pulses for one cycle per accepted byte write on that lane.
`timescale 1ns/1ps
module uprc_unlock #(
    parameter [7:0] KEY1 = 8'h00,
    parameter [7:0] KEY2 = 8'h00
) (
    input wire clk,
    input wire nrst,
    input wire wr,
    input wire [7:0] data,
    output wire open
);
    localparam ST_IDLE = 2'h0;
    localparam ST_KEY1 = 2'h1;
    localparam ST_OPEN = 2'h2;

    reg [1:0] st_q;
    reg [1:0] st_d;

    assign open = (st_q == ST_OPEN);

    always @* begin
        st_d = st_q;
        if (wr) begin
            case (st_q)
                ST_IDLE: st_d = (data == KEY1) ? ST_KEY1 : ST_IDLE;
                ST_KEY1: st_d = (data == KEY2) ? ST_OPEN :
                                ((data == KEY1) ? ST_KEY1 : ST_IDLE);
                // The write after the keys is the payload; lock again after it
                ST_OPEN: st_d = ST_IDLE;
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // uprc_unlock

//--- src/uprc_refdiv.v
// Power-of-two reference divider counting base-clock cycles given per clk step.
// Assumes inc never exceeds 8 base cycles per step.
`timescale 1ns/1ps
module uprc_refdiv (
    input wire clk,
    input wire nrst,
    input wire hold,
    input wire [3:0] inc,
    input wire [3:0] div,
    input wire pass,
    input wire pass_lvl,
    output reg q
);
    reg [15:0] acc_q;
    wire [16:0] thr;
    wire [16:0] acc_n;

    // Half periods: a divide by 2^div toggles every 2^div half base cycles
    assign thr = 17'h00001 << div;
    assign acc_n = {1'b0, acc_q} + {12'h000, inc, 1'b0};

    always @(posedge clk) begin
        if (!nrst || hold) begin
            acc_q <= 16'h0000;
            q <= 1'b0;
        end else if (div == 4'h0) begin
            acc_q <= 16'h0000;
            if (pass) begin
                q <= pass_lvl;
            end else if (inc != 4'h0) begin
                q <= ~q;
            end
        end else if (acc_n >= thr) begin
            // Slow edges only: one toggle per step limits fast ratios
            acc_q <= acc_n[15:0] - thr[15:0];
            q <= ~q;
        end else begin
            acc_q <= acc_n[15:0];
        end
    end
endmodule // uprc_refdiv

//--- test/uprc_top_chk.sv
// Port checker for the USB PLL and reference clock block.
// Assumes zero-wait APB at the offsets of the block's register header.
`timescale 1ns/1ps
module uprc_chk (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire pre_tick,
    input wire usb_clk_ok,
    input wire [15:0] usb_cycle_cnt_q,
    input wire secondary_osc_driver_en,
    input wire secondary_osc_low_drive,
    input wire secondary_pins_digital,
    input wire ref_clk_pin_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire wr_acc = psel && penable && pwrite;
    chk_apb_ready: assert property (psel |-> pready)
        else $error("pready low");
    chk_ref_enable: assert property (wr_acc && pstrb[1] && paddr == 8'h08
        |=> ref_clk_pin_oe == $past(pwdata[15])) else $error("ref enable not taken");
    chk_ref_unimpl: assert property (psel && !pwrite && paddr == 8'h08
        |-> (prdata & 32'hFFFF40FF) == 32'h0) else $error("ref reserved bits set");
    chk_pins_free: assert property (secondary_pins_digital
        |-> !secondary_osc_driver_en && !secondary_osc_low_drive) else $error("pins shared");
    chk_ext_driver: assert property (wr_acc && pstrb[0] && paddr == 8'h0C
        && pwdata[5:4] == 2'h2 |=> !secondary_osc_driver_en [*2]) else $error("driver on");
    chk_high_drive: assert property (wr_acc && pstrb[0] && paddr == 8'h0C
        && pwdata[5:4] != 2'h1 |=> !secondary_osc_low_drive) else $error("low drive on");
    chk_usb_step: assert property (pre_tick && usb_clk_ok
        |=> usb_cycle_cnt_q == $past(usb_cycle_cnt_q) + 16'h000C) else $error("usb step");
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
        else $error("no error on unmapped address");
endmodule // uprc_chk
bind uprc_top uprc_chk u_chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pre_tick, .usb_clk_ok, .usb_cycle_cnt_q,
    .secondary_osc_driver_en, .secondary_osc_low_drive, .secondary_pins_digital,
    .ref_clk_pin_oe);

//--- test/uprc_osc_model.sv
// Crystal and external clock sources seen on the oscillator pins.
// Assumes clk is the bench clock; the sources are stepped from it.
`timescale 1ns/1ps
module uprc_osc_model (
    input wire clk,
    input wire nrst,
    input wire primary_osc_power,
    output reg posc_clk_in,
    output reg secondary_osc_clk_in,
    output reg secondary_ext_clk_pin
);
    reg [3:0] cnt_q;
    always @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= 4'h0;
            posc_clk_in <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            // An unpowered crystal stops instead of holding its last swing
            posc_clk_in <= primary_osc_power ? ~posc_clk_in : 1'b0;
        end
        secondary_osc_clk_in <= cnt_q[3];
        secondary_ext_clk_pin <= cnt_q[2];
    end
endmodule // uprc_osc_model

//--- test/uprc_top_tb.sv
// Self-checking bench for the USB PLL and reference clock block.
// Assumes the oscillator model on the pins and the checker bound to the top.
`timescale 1ns/1ps
module uprc_top_tb;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [3:0] pstrb = 4'h0;
    reg secondary_osc_request = 1'b0;
    reg usb_en = 1'b0;
    reg sleep = 1'b0;
    reg [31:0] r;
    reg e;
    wire [31:0] prdata;
    wire [15:0] usb_cycle_cnt_q, sys_cycle_cnt_q;
    wire pready, pslverr, posc_clk_in, secondary_ext_clk_pin, secondary_osc_clk_in, pre_tick;
    wire usb_clk_ok, secondary_osc_run, secondary_osc_driver_en, secondary_osc_low_drive;
    wire secondary_pins_digital, secondary_clk, primary_osc_power, half_freq_clk_out;
    wire half_freq_clk_out_oe, ref_clk_pin, ref_clk_pin_oe;
    integer error_cnt = 0;
    integer checks = 0;
    always #25 clk = ~clk;
    uprc_top dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .posc_clk_in, .secondary_ext_clk_pin, .secondary_osc_clk_in,
        .secondary_osc_request, .usb_en, .sleep, .pre_tick, .usb_clk_ok, .usb_cycle_cnt_q,
        .sys_cycle_cnt_q, .secondary_osc_run, .secondary_osc_driver_en,
        .secondary_osc_low_drive, .secondary_pins_digital, .secondary_clk,
        .primary_osc_power, .half_freq_clk_out, .half_freq_clk_out_oe, .ref_clk_pin,
        .ref_clk_pin_oe);
    uprc_osc_model osc (.clk, .nrst, .primary_osc_power, .posc_clk_in,
        .secondary_osc_clk_in, .secondary_ext_clk_pin);
    task tally_and_finish;
        begin
            if (error_cnt == 0 && checks > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            pstrb <= s;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge clk);
            end
            if (n >= 50) begin
                error_cnt = error_cnt + 1;
                $display("BAD pready expected 1 seen %b", pready);
            end
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Clocks from one prescaler pulse to the next, bounded
    task tick(output integer n);
        begin
            n = 1;
            @(negedge clk);
            while (pre_tick !== 1'b1 && n < 400) begin
                n = n + 1;
                @(negedge clk);
            end
        end
    endtask
    task toggles(output integer t);
        integer i;
        reg p;
        begin
            t = 0;
            // Let leftover phase from a larger divisor drain before counting
            repeat (12) @(negedge clk);
            p = ref_clk_pin;
            for (i = 0; i < 16; i = i + 1) begin
                @(negedge clk);
                if (ref_clk_pin !== p) t = t + 1;
                p = ref_clk_pin;
            end
        end
    endtask
    task t_prediv;
        integer c, n, k;
        begin
            for (c = 0; c < 8; c = c + 1) begin
                apb(1'b1, 8'h0C, 32'h30 | c, 4'h1);
                for (k = 0; k < 3; k = k + 1) tick(n);
                chk("pre_period", (c < 6 ? c + 1 : c == 6 ? 8 : 12) * 2, n);
            end
        end
    endtask
    task t_unlock;
        begin
            usb_en <= 1'b1;
            apb(1'b1, 8'h04, 32'h20, 4'h1);
            apb(1'b1, 8'h00, 32'h0300, 4'h2);
            apb(1'b1, 8'h00, 32'h01, 4'h1);
            apb(1'b0, 8'h00, 32'h0, 4'h0);
            chk("locked", 32'h0, r & 32'h7701);
            @(negedge clk);
            chk("usb_ok_off", 0, usb_clk_ok);
            apb(1'b1, 8'h00, 32'h7800, 4'h2);
            apb(1'b1, 8'h00, 32'h9A00, 4'h2);
            apb(1'b1, 8'h00, 32'h0300, 4'h2);
            apb(1'b1, 8'h00, 32'h46, 4'h1);
            apb(1'b1, 8'h00, 32'h57, 4'h1);
            apb(1'b1, 8'h00, 32'h01, 4'h1);
            apb(1'b0, 8'h00, 32'h0, 4'h0);
            chk("switched", 32'h3300, r & 32'h7701);
            @(negedge clk);
            chk("usb_ok_on", 1, usb_clk_ok);
        end
    endtask
    task t_sys;
        integer p, n;
        reg [15:0] a;
        reg [15:0] b;
        begin
            for (p = 0; p < 4; p = p + 1) begin
                apb(1'b1, 8'h04, 32'h20 | (p << 6), 4'h1);
                apb(1'b0, 8'h04, 32'h0, 4'h0);
                chk("postdiv", p, r[7:6]);
                tick(n);
                a = sys_cycle_cnt_q;
                b = usb_cycle_cnt_q;
                tick(n);
                chk("sys_step", 8 >> p, sys_cycle_cnt_q - a);
                chk("usb_step", 12, usb_cycle_cnt_q - b);
            end
        end
    endtask
    task t_sec;
        integer m;
        begin
            secondary_osc_request <= 1'b1;
            for (m = 0; m < 4; m = m + 1) begin
                apb(1'b1, 8'h0C, m << 4, 4'h1);
                @(negedge clk);
                chk("pins_dig", m == 0, secondary_pins_digital);
                chk("osc_run", m != 0, secondary_osc_run);
                chk("low_drive", m == 1, secondary_osc_low_drive);
                chk("driver_en", m[0], secondary_osc_driver_en);
                if (m == 2) chk("ext_clk", secondary_ext_clk_pin, secondary_clk);
            end
            secondary_osc_request <= 1'b0;
            apb(1'b1, 8'h00, 32'h46, 4'h1);
            apb(1'b1, 8'h00, 32'h57, 4'h1);
            apb(1'b1, 8'h00, 32'h02, 4'h1);
            @(negedge clk);
            chk("force_on", 1, secondary_osc_driver_en);
            apb(1'b1, 8'h0C, 32'h20, 4'h1);
            @(negedge clk);
            chk("force_ext", 0, secondary_osc_driver_en);
        end
    endtask
    task t_ref;
        integer d, t;
        reg h;
        begin
            apb(1'b1, 8'h08, 32'hFFFFFFFF, 4'h3);
            apb(1'b0, 8'h08, 32'h0, 4'h0);
            chk("ref_rd", 32'hBF00, r);
            chk("ref_oe", 1, ref_clk_pin_oe);
            for (d = 1; d < 4; d = d + 1) begin
                apb(1'b1, 8'h08, 32'h9000 | (d << 8), 4'h2);
                toggles(t);
                chk("ref_edges", 16 >> d, t);
            end
            // System base: one 4 MHz tick per two clocks, postscaler 11 adds one cycle
            apb(1'b1, 8'h08, 32'h8300, 4'h2);
            toggles(t);
            chk("ref_sys", 2, t);
            @(posedge clk);
            sleep <= 1'b1;
            toggles(t);
            chk("ref_slp_off", 0, t + ref_clk_pin);
            chk("posc_pwr", 0, primary_osc_power);
            apb(1'b1, 8'h0C, 32'hC0, 4'h1);
            apb(1'b1, 8'h08, 32'hB100, 4'h2);
            toggles(t);
            chk("ref_slp_on", 8, t);
            @(posedge clk);
            sleep <= 1'b0;
            apb(1'b1, 8'h08, 32'h0, 4'h2);
            toggles(t);
            chk("ref_off", 0, t + ref_clk_pin_oe + ref_clk_pin);
            chk("half_oe", 1, half_freq_clk_out_oe);
            h = half_freq_clk_out;
            repeat (2) @(negedge clk);
            chk("half_clk", !h, half_freq_clk_out);
            apb(1'b0, 8'h20, 32'h0, 4'h0);
            chk("unmapped", 0, r);
            chk("pslverr", 1, e);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_unlock;
        t_prediv;
        t_sys;
        t_sec;
        t_ref;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
endmodule // uprc_top_tb
